/* src/rsc_pkg.sv */
// Purpose: Constants for the reset source combiner
// Assumes: 50 MHz core clock, APB register access
// Notes:   One register word holds the reset cause and control bits
package rsc_pkg;
    localparam int          CLK_HZ             = 50_000_000;
    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CAUSE_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_OSC_STATUS    = 12'h004;
    // Field positions in the reset cause and control register
    localparam int          BIT_TRAP           = 15;
    localparam int          BIT_ILLOP          = 14;
    localparam int          BIT_CFGMIS         = 9;
    localparam int          BIT_VREG_STBY      = 8;
    localparam int          BIT_EXTPIN         = 7;
    localparam int          BIT_SWRST          = 6;
    localparam int          BIT_WDT_EN         = 5;
    localparam int          BIT_WATCHDOG_TIMEOUT_FLAG           = 4;
    localparam int          BIT_SLEEP          = 3;
    localparam int          BIT_IDLE           = 2;
    localparam int          BIT_BROWN          = 1;
    localparam int          BIT_POWERON        = 0;
    localparam logic [15:0] CAUSE_IMPL_MASK    = 16'hC3FF;
    localparam logic [15:0] CAUSE_POR_VALUE    = 16'h0003;
    // Oscillator selection codes
    localparam logic [2:0]  OSC_FAST_RC        = 3'h0;
    // Timing
    localparam int          POWER_UP_DELAY_MS  = 64;
    localparam int          POWER_UP_CYCLES    = POWER_UP_DELAY_MS * (CLK_HZ / 1000);
    localparam int          POWER_ON_DELAY_US  = 10;
    localparam int          POWER_ON_CYCLES    = POWER_ON_DELAY_US * (CLK_HZ / 1000000);
    localparam int          STATE_RST_DELAY_US = 10;
    localparam int          STATE_RST_CYCLES   = STATE_RST_DELAY_US * (CLK_HZ / 1000000);
    localparam int          OST_WIDTH          = 10;
    localparam int          OST_PERIODS        = 1024;
    localparam int          LOCK_DELAY_US      = 100;
    localparam int          LOCK_CYCLES        = LOCK_DELAY_US * (CLK_HZ / 1000000);
    localparam int          CNT_W              = 32;

    typedef enum logic [3:0]
    {
        ST_POR_WAIT  = 4'b0001,
        ST_PWRT_WAIT = 4'b0010,
        ST_RST_WAIT  = 4'b0100,
        ST_RUN       = 4'b1000
    } rsc_state_t;
endpackage

/* src/rsc_reset_combiner.sv */
// Purpose: Combines reset sources, records the cause, times the release
// Assumes: All inputs synchronous to core_clk_in; por_in is a level from the supply monitor
// Notes:   Oscillator start-up counts on osc_tick_in, one pulse per oscillator period
`timescale 1ns/1ps
module rsc_reset_combiner
    import rsc_pkg::*;
#(
    parameter int POR_CYCLES_P  = POWER_ON_CYCLES,
    parameter int PWRT_CYCLES_P = POWER_UP_CYCLES,
    parameter int TRST_CYCLES_P = STATE_RST_CYCLES,
    parameter int LOCK_CYCLES_P = LOCK_CYCLES
)
(
    input  wire logic        core_clk_in,
    input  wire logic        reset_n_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Reset sources
    input  wire logic        por_in,
    input  wire logic        brownout_in,
    input  wire logic        master_clear_pin_n_in,
    input  wire logic        reset_instr_in,
    input  wire logic        watchdog_timeout_in,
    input  wire logic        config_mismatch_in,
    input  wire logic        trap_conflict_in,
    input  wire logic        illegal_op_in,
    // Power-saving instruction events
    input  wire logic        sleep_instr_in,
    input  wire logic        idle_instr_in,
    // Configuration and oscillator status
    input  wire logic        clock_switch_en_in,
    input  wire logic        two_speed_en_in,
    input  wire logic        failsafe_en_in,
    input  wire logic        regulator_enable_pin_in,
    input  wire logic        watchdog_fuse_enable_in,
    input  wire logic        pll_used_in,
    input  wire logic        crystal_used_in,
    input  wire logic [2:0]  new_osc_config_field_in,
    input  wire logic [2:0]  current_osc_field_in,
    input  wire logic        osc_tick_in,
    input  wire logic        osc_valid_in,
    // Outputs
    output logic             master_system_reset_out,
    output logic             code_run_out,
    output logic [2:0]       osc_select_out,
    output logic             watchdog_enable_out,
    output logic             regulator_standby_out,
    output logic             failsafe_active_out
);

    // ***************************************************************
    // Reset source decode
    // ***************************************************************
    wire logic any_source;
    wire logic pwrup_source;
    assign any_source = por_in | brownout_in | ~master_clear_pin_n_in | reset_instr_in
                      | watchdog_timeout_in | config_mismatch_in | trap_conflict_in
                      | illegal_op_in;
    assign pwrup_source = por_in | brownout_in;

    // ***************************************************************
    // APB decode
    // ***************************************************************
    wire logic apb_wr;
    wire logic apb_rd;
    wire logic hit_cause;
    wire logic hit_osc;
    assign hit_cause = (paddr_in == ADDR_CAUSE_CTRL);
    assign hit_osc   = (paddr_in == ADDR_OSC_STATUS);
    // Write lands on the access edge, where the master sees pready
    assign apb_wr    = psel_in & penable_in & pwrite_in & pready_out;
    assign apb_rd    = psel_in & ~penable_in & ~pwrite_in;

    // ***************************************************************
    // Cause register
    // ***************************************************************
    logic [15:0] cause_r;
    logic [15:0] cause_nxt;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    always_comb
    begin
        hw_set                = 16'h0000;
        hw_set[BIT_TRAP]      = trap_conflict_in;
        hw_set[BIT_ILLOP]     = illegal_op_in;
        hw_set[BIT_CFGMIS]    = config_mismatch_in;
        hw_set[BIT_EXTPIN]    = ~master_clear_pin_n_in;
        hw_set[BIT_SWRST]     = reset_instr_in;
        hw_set[BIT_WATCHDOG_TIMEOUT_FLAG]      = watchdog_timeout_in;
        hw_set[BIT_SLEEP]     = sleep_instr_in;
        hw_set[BIT_IDLE]      = idle_instr_in;
        hw_set[BIT_BROWN]     = brownout_in | por_in;
        hw_set[BIT_POWERON]   = por_in;
        hw_clr                = 16'h0000;
        hw_clr[BIT_WATCHDOG_TIMEOUT_FLAG]      = sleep_instr_in | idle_instr_in;
        cause_nxt = cause_r & ~hw_clr;
        if (apb_wr && hit_cause)
        begin
            cause_nxt = pwdata_in[15:0];
        end
        // Hardware set applied last so it beats a same-cycle write
        cause_nxt = (cause_nxt | hw_set) & CAUSE_IMPL_MASK;
        if (por_in)
        begin
            cause_nxt = CAUSE_POR_VALUE;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            cause_r <= CAUSE_POR_VALUE;
        else
            cause_r <= cause_nxt;
    end

    // ***************************************************************
    // Release sequencing
    // ***************************************************************
    rsc_state_t  state_r;
    rsc_state_t  state_nxt;
    logic [CNT_W-1:0] dly_r;
    logic [CNT_W-1:0] dly_nxt;
    wire logic   dly_done;
    assign dly_done = (dly_r == '0);

    // Load value of the delay counter on entry to each wait phase
    function automatic logic [CNT_W-1:0] phase_load(input rsc_state_t st);
        logic [CNT_W-1:0] val;
        val = '0;
        case (st)
            ST_POR_WAIT:  val = CNT_W'(POR_CYCLES_P);
            ST_PWRT_WAIT: val = CNT_W'(PWRT_CYCLES_P);
            ST_RST_WAIT:  val = CNT_W'(TRST_CYCLES_P);
            default:      val = '0;
        endcase
        return val;
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        dly_nxt   = dly_done ? dly_r : dly_r - 1'b1;
        if (por_in)
        begin
            state_nxt = ST_POR_WAIT;
            dly_nxt   = phase_load(ST_POR_WAIT);
        end
        else if (brownout_in)
        begin
            state_nxt = ST_PWRT_WAIT;
            dly_nxt   = phase_load(ST_PWRT_WAIT);
        end
        else if (any_source)
        begin
            state_nxt = ST_RST_WAIT;
            dly_nxt   = phase_load(ST_RST_WAIT);
        end
        else
        begin
            case (state_r)
                ST_POR_WAIT:
                begin
                    if (dly_done)
                    begin
                        state_nxt = ST_PWRT_WAIT;
                        dly_nxt   = phase_load(ST_PWRT_WAIT);
                    end
                end
                ST_PWRT_WAIT:
                begin
                    if (dly_done)
                    begin
                        state_nxt = ST_RST_WAIT;
                        dly_nxt   = phase_load(ST_RST_WAIT);
                    end
                end
                ST_RST_WAIT:
                begin
                    if (dly_done)
                        state_nxt = ST_RUN;
                end
                ST_RUN:    state_nxt = ST_RUN;
                default:   state_nxt = ST_POR_WAIT;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            state_r <= ST_POR_WAIT;
            dly_r   <= phase_load(ST_POR_WAIT);
        end
        else
        begin
            state_r <= state_nxt;
            dly_r   <= dly_nxt;
        end
    end

    // ***************************************************************
    // Clock source selection and oscillator start-up
    // ***************************************************************
    logic [2:0]  osc_sel_r;
    logic [OST_WIDTH-1:0] ost_r;
    logic        ost_done_r;
    logic [CNT_W-1:0] lock_r;
    logic        fs_r;
    logic        fs_fallback_r;
    wire logic [2:0] osc_reset_sel;
    wire logic   lock_done;
    wire logic   clock_ready;
    wire logic   in_reset;
    wire logic   releasing;

    // Power-up resets, or any reset with clock switching off, fall back to the fuse field; others keep what was running
    assign osc_reset_sel = (!clock_switch_en_in || pwrup_source) ? new_osc_config_field_in
                         : current_osc_field_in;
    assign lock_done   = !pll_used_in || (lock_r == '0);
    assign clock_ready = (ost_done_r || !crystal_used_in) && lock_done && osc_valid_in;
    assign in_reset    = any_source || (state_r != ST_RUN);
    assign releasing   = (state_r == ST_RST_WAIT) && dly_done && !any_source;

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            osc_sel_r <= OSC_FAST_RC;
        else if (por_in && two_speed_en_in)
            osc_sel_r <= OSC_FAST_RC;
        else if (any_source)
            osc_sel_r <= osc_reset_sel;
        else if (releasing && failsafe_en_in && !osc_valid_in)
            osc_sel_r <= OSC_FAST_RC;
    end

    // Start-up timer and lock wait run during the reset delay, not after it
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in || any_source)
        begin
            ost_r      <= '0;
            ost_done_r <= 1'b0;
            lock_r     <= CNT_W'(LOCK_CYCLES_P);
        end
        else
        begin
            if (osc_tick_in && !ost_done_r)
            begin
                ost_r <= ost_r + 1'b1;
                if (ost_r == OST_WIDTH'(OST_PERIODS - 1))
                    ost_done_r <= 1'b1;
            end
            if (lock_r != '0)
                lock_r <= lock_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in || in_reset)
        begin
            fs_r          <= 1'b0;
        end
        else
        begin
            fs_r <= failsafe_en_in;
        end
    end

    // Records that the release found no clock and fell back to the fast RC oscillator
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in || any_source)
            fs_fallback_r <= 1'b0;
        else if (releasing && failsafe_en_in && !osc_valid_in)
            fs_fallback_r <= 1'b1;
    end

    // ***************************************************************
    // Outputs and APB read
    // ***************************************************************
    wire logic [31:0] osc_status_word;
    wire logic [31:0] read_word;
    assign osc_status_word = {24'h00_0000, fs_fallback_r, clock_ready, ost_done_r,
                              (state_r == ST_RUN), 1'b0, osc_sel_r};
    // Unmapped offsets read as zero
    assign read_word = hit_cause ? {16'h0000, cause_r}
                     : hit_osc   ? osc_status_word
                     : 32'h0000_0000;

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            master_system_reset_out <= 1'b1;
            code_run_out            <= 1'b0;
            failsafe_active_out     <= 1'b0;
            osc_select_out          <= OSC_FAST_RC;
        end
        else
        begin
            master_system_reset_out <= in_reset;
            code_run_out            <= !in_reset && clock_ready;
            // Drops with the reset so the monitor never watches a clock in reset
            failsafe_active_out     <= fs_r && !in_reset;
            osc_select_out          <= osc_sel_r;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            watchdog_enable_out     <= 1'b0;
            regulator_standby_out   <= 1'b1;
        end
        else
        begin
            watchdog_enable_out     <= watchdog_fuse_enable_in
                                     | cause_r[BIT_WDT_EN];
            regulator_standby_out   <= ~cause_r[BIT_VREG_STBY];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            prdata_out              <= 32'h0000_0000;
            pready_out              <= 1'b0;
            pslverr_out             <= 1'b0;
        end
        else
        begin
            pready_out              <= psel_in & ~penable_in;
            pslverr_out             <= psel_in & ~penable_in & ~(hit_cause | hit_osc);
            if (apb_rd)
                prdata_out <= read_word;
        end
    end

endmodule // rsc_reset_combiner

/* dv/rsc_osc_model.sv */
// Purpose: Oscillator subsystem stand-in for the reset source combiner
// Assumes: One oscillator tick every TICK_DIV core cycles
// Notes:   Valid follows valid_en_in, so the bench can command a dead clock
`timescale 1ns/1ps
module rsc_osc_model
#(
    parameter int TICK_DIV = 2
)
(
    input  wire logic core_clk_in,
    input  wire logic valid_en_in,
    output logic      osc_tick_out  = 1'b0,
    output logic      osc_valid_out = 1'b0
);
    int div_r = 0;
    // A dead oscillator gives no ticks at all, not just a low valid flag
    always_ff @(posedge core_clk_in)
    begin
        div_r         <= (div_r + 1) % TICK_DIV;
        osc_tick_out  <= valid_en_in && (div_r == 0);
        osc_valid_out <= valid_en_in;
    end
endmodule // rsc_osc_model

/* dv/rsc_reset_combiner_asserts.sv */
// Purpose: Port-level checks for the reset source combiner
// Assumes: Bound to rsc_reset_combiner, one clock domain
// Notes:   Hold check needs the state reset count at 6 or more
`timescale 1ns/1ps
module rsc_reset_combiner_asserts
(
    input wire logic        core_clk_in,
    input wire logic        reset_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        por_in,
    input wire logic        brownout_in,
    input wire logic        master_clear_pin_n_in,
    input wire logic        reset_instr_in,
    input wire logic        watchdog_timeout_in,
    input wire logic        config_mismatch_in,
    input wire logic        trap_conflict_in,
    input wire logic        illegal_op_in,
    input wire logic        watchdog_fuse_enable_in,
    input wire logic        master_system_reset_out,
    input wire logic        code_run_out,
    input wire logic        watchdog_enable_out,
    input wire logic        failsafe_active_out
);
    // ***********************************************
    // Checks
    // ***********************************************
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic setup_w = psel_in && !penable_in;
    property p_src_reset;
        (por_in || brownout_in || reset_instr_in || watchdog_timeout_in || config_mismatch_in
         || trap_conflict_in || illegal_op_in) |=> master_system_reset_out;
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source did not reset");
    property p_pin_reset;
        !master_clear_pin_n_in |=> master_system_reset_out;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin did not reset");
    property p_hold;
        (trap_conflict_in && code_run_out) |=> master_system_reset_out[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("reset released too early");
    property p_fuse;
        watchdog_fuse_enable_in |=> watchdog_enable_out;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse did not force watchdog");
    property p_ready;
        setup_w |=> pready_out ##1 !pready_out;
    endproperty
    a_ready: assert property (p_ready) else $error("register access not answered");
    property p_unimpl;
        (setup_w && !pwrite_in && paddr_in == 12'h000)
            |=> (prdata_out[31:16] == 16'h0000) && (prdata_out[13:10] == 4'h0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused bits not zero");
    property p_failsafe;
        failsafe_active_out |-> !master_system_reset_out;
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("monitor on in reset");
    property p_run;
        code_run_out |-> !master_system_reset_out;
    endproperty
    a_run: assert property (p_run) else $error("code runs in reset");
endmodule // rsc_reset_combiner_asserts

bind rsc_reset_combiner rsc_reset_combiner_asserts rsc_reset_combiner_asserts_inst
(
    .core_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
    .pready_out, .pslverr_out, .por_in, .brownout_in, .master_clear_pin_n_in,
    .reset_instr_in, .watchdog_timeout_in, .config_mismatch_in, .trap_conflict_in,
    .illegal_op_in, .watchdog_fuse_enable_in, .master_system_reset_out, .code_run_out,
    .watchdog_enable_out, .failsafe_active_out
);

/* dv/tb.sv */
// Purpose: Self-checking bench for the reset source combiner
// Assumes: Small delay counts, oscillator ticks every second cycle
// Notes:   Release times are checked with a few cycles of slack
`timescale 1ns/1ps
module tb;
    import rsc_pkg::*;
    // ***********************************************
    // Stimulus and checks
    // ***********************************************
    localparam int PO = 6, PW = 10, TR = 8;
    localparam int BITS[10] = '{0, BIT_BROWN, BIT_EXTPIN, BIT_SWRST, BIT_WATCHDOG_TIMEOUT_FLAG, BIT_CFGMIS,
                                BIT_TRAP, BIT_ILLOP, BIT_SLEEP, BIT_IDLE};
    logic core_clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, rd_v, d;
    logic [9:0] src = 0;
    logic sw = 1, two_sp = 1, fuse = 0, ven = 1, pready_out, pslverr_out, osc_tick, osc_valid;
    logic master_system_reset_out, code_run_out, watchdog_enable_out, regulator_standby_out;
    logic failsafe_active_out, err_v;
    logic [2:0] osc_select_out;
    logic [2:0] new_f = 3'h5, cur_f = 3'h3;
    int seed = 88, miscompares = 0, comparisons = 0, n, m;
    rsc_osc_model rsc_osc_model_inst (.core_clk_in, .valid_en_in(ven),
        .osc_tick_out(osc_tick), .osc_valid_out(osc_valid));
    rsc_reset_combiner #(.POR_CYCLES_P(PO), .PWRT_CYCLES_P(PW), .TRST_CYCLES_P(TR),
        .LOCK_CYCLES_P(12)) rsc_reset_combiner_inst (.core_clk_in, .reset_n_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .por_in(src[0]), .brownout_in(src[1]), .master_clear_pin_n_in(~src[2]),
        .reset_instr_in(src[3]), .watchdog_timeout_in(src[4]), .config_mismatch_in(src[5]),
        .trap_conflict_in(src[6]), .illegal_op_in(src[7]), .sleep_instr_in(src[8]),
        .idle_instr_in(src[9]), .clock_switch_en_in(sw), .two_speed_en_in(two_sp),
        .failsafe_en_in(1'b1), .regulator_enable_pin_in(1'b0), .watchdog_fuse_enable_in(fuse),
        .pll_used_in(1'b1), .crystal_used_in(1'b1), .new_osc_config_field_in(new_f),
        .current_osc_field_in(cur_f), .osc_tick_in(osc_tick), .osc_valid_in(osc_valid),
        .master_system_reset_out, .code_run_out, .osc_select_out, .watchdog_enable_out,
        .regulator_standby_out, .failsafe_active_out);

    initial
    begin
        forever #10 core_clk_in = ~core_clk_in;
    end

    function automatic logic [15:0] flag_of(input int i);
        return (i == 0) ? CAUSE_POR_VALUE : 16'h0001 << BITS[i];
    endfunction
    function automatic int delay_of(input int i);
        // Each wait phase also spends one cycle on its terminal count
        return (i == 0) ? PO + PW + TR + 3 : (i == 1) ? PW + TR + 2 : TR + 1;
    endfunction
    function automatic logic [2:0] osc_of(input int i, input logic s);
        return (i == 0) ? OSC_FAST_RC : (!s || i < 2) ? new_f : cur_f;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // The request stands until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= v;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        @(posedge core_clk_in iff pready_out === 1'b1);
        rd_v = prdata_out;
        err_v = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic pulse(input int i);
        @(posedge core_clk_in);
        src[i] <= 1'b1;
        @(posedge core_clk_in);
        src[i] <= 1'b0;
    endtask
    // Bounded wait: which 0 waits for reset release, 1 for code running
    task automatic wait_for(input logic which, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge core_clk_in);
            cnt++;
        end
        while ((which ? code_run_out !== 1'b1 : master_system_reset_out !== 1'b0)
               && cnt < 5000);
    endtask
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #(20 * 60000);
        miscompares++;
        finish_test();
    end

    initial
    begin
        repeat (5) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        wait_for(0, n);
        check(n >= delay_of(0) && n <= delay_of(0) + 4, 1);
        check(osc_select_out, OSC_FAST_RC);
        wait_for(1, m);
        check(n + m >= 2 * OST_PERIODS - 4, 1);
        apb(0, ADDR_CAUSE_CTRL, 0);
        check(rd_v, CAUSE_POR_VALUE);
        apb(0, 12'h008, 0);
        check(err_v, 1);
        check(rd_v, 32'h0000_0000);
        two_sp <= 1'b0;
        $display("power-up test done");
        for (int k = 0; k < 4; k++)
        begin
            d = (k == 0) ? 32'hFFFFFFFF : $random(seed);
            fuse <= k[0];
            apb(1, ADDR_CAUSE_CTRL, d);
            apb(0, ADDR_CAUSE_CTRL, 0);
            check(rd_v, {16'h0, d[15:0] & CAUSE_IMPL_MASK});
            check(master_system_reset_out, 0);
            check(regulator_standby_out, !d[BIT_VREG_STBY]);
            check(watchdog_enable_out, d[BIT_WDT_EN] | k[0]);
        end
        $display("register test done");
        for (int i = 0; i < 8; i++)
        begin
            sw <= (i % 3) != 2;
            two_sp <= (i == 0);
            d = $random(seed);
            new_f <= {1'b1, d[1:0]};
            cur_f <= {1'b0, d[1], 1'b1};
            apb(1, ADDR_CAUSE_CTRL, 0);
            pulse(i);
            wait_for(0, n);
            check(n >= delay_of(i) && n <= delay_of(i) + 4, 1);
            check(osc_select_out, osc_of(i, sw));
            wait_for(1, m);
            apb(0, ADDR_CAUSE_CTRL, 0);
            check(rd_v, flag_of(i));
        end
        $display("reset source test done");
        apb(1, ADDR_CAUSE_CTRL, 32'h1 << BIT_WATCHDOG_TIMEOUT_FLAG);
        pulse(9);
        apb(0, ADDR_CAUSE_CTRL, 0);
        check(rd_v, flag_of(9));
        // Sleep lands on the write's access edge, where the write takes effect
        fork
            begin
                @(posedge core_clk_in);
                pulse(8);
            end
            apb(1, ADDR_CAUSE_CTRL, 0);
        join
        apb(0, ADDR_CAUSE_CTRL, 0);
        check(rd_v, flag_of(8));
        $display("power-saving test done");
        ven <= 1'b0;
        pulse(2);
        wait_for(0, n);
        @(posedge core_clk_in);
        check(osc_select_out, OSC_FAST_RC);
        check(failsafe_active_out, 1);
        check(code_run_out, 0);
        apb(0, ADDR_OSC_STATUS, 0);
        check(rd_v, 32'h0000_0090);
        ven <= 1'b1;
        wait_for(1, m);
        check(code_run_out, 1);
        $display("fail-safe test done");
        finish_test();
    end
endmodule // tb
